// file: core/txli_pkg.sv
/*
  Package for the transmit line interface input stage: register map,
  field positions, reset values, mode encodings and carrier structs.
  Assumes an AHB-Lite slave with 32-bit data and whole-word accesses.
*/
package txli_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFS   = 8'h00;
  localparam logic [7:0] STATUS_OFFS = 8'h04;

  // Control register fields
  localparam int CTRL_HOST_BIT   = 0;
  localparam int CTRL_SINGLE_BIT = 1;
  localparam int CTRL_EDGE_BIT   = 2;
  localparam int CTRL_RATE_LSB   = 4;
  localparam int CTRL_RATE_W     = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_0037;

  // Status register fields
  localparam int STAT_ON_BIT     = 0;
  localparam int STAT_RISE_BIT   = 1;
  localparam int STAT_LBO_BIT    = 2;
  localparam int STAT_SCLK_BIT   = 3;
  localparam int STAT_POS_BIT    = 4;
  localparam int STAT_NEG_BIT    = 5;

  // Line rate encoding
  typedef enum logic [1:0] {
    TXLI_RATE_E3  = 2'b00,
    TXLI_RATE_DS3 = 2'b01,
    TXLI_RATE_STS = 2'b10
  } txli_rate_t;

  // AHB transfer type codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;

  // Data pins from the terminal equipment
  typedef struct packed {
    logic pos;
    logic neg;
  } txli_rails_t;

  // Configuration as seen by the link domain
  typedef struct packed {
    logic host_mode;
    logic single_rail;
    logic sample_rise;
  } txli_cfg_t;

  // Line driver outputs
  typedef struct packed {
    logic tip;
    logic ring;
    logic tip_oe;
    logic ring_oe;
    logic lbo_en;
  } txli_line_t;

endpackage

// file: core/txli_sampler.sv
/*
  Link-domain sampler: captures both rails on the chosen edge of the
  transmit bit clock and forms tip/ring marks.
  Assumes configuration inputs are quasi-static, already synchronised.
*/
`timescale 1ns/100ps
module txli_sampler (
  // Link clock
  input  wire logic              tx_bit_clock_i,
  input  wire logic              link_rst_n_i,
  // Configuration and data
  input  wire txli_pkg::txli_cfg_t   cfg_i,
  input  wire txli_pkg::txli_rails_t rails_i,
  // Marks, in tx_bit_clock domain
  output logic                   pos_mark_o,
  output logic                   neg_mark_o
);
  import txli_pkg::*;

  typedef struct packed {
    logic rise_pos;
    logic rise_neg;
  } txli_rise_st_t;

  txli_rails_t   fall_ff;
  txli_rise_st_t rise_ff;
  txli_rise_st_t nxt_rise;
  txli_rails_t   nxt_fall;

  // Both edges capture; the selected edge's copy is used
  always_comb begin
    nxt_rise.rise_pos = rails_i.pos;
    nxt_rise.rise_neg = rails_i.neg & ~cfg_i.single_rail;
    nxt_fall.pos      = rails_i.pos;
    nxt_fall.neg      = rails_i.neg & ~cfg_i.single_rail;
    if (!link_rst_n_i) begin
      nxt_rise = '0;
      nxt_fall = '0;
    end
  end

  always_ff @(posedge tx_bit_clock_i) begin
    rise_ff <= nxt_rise;
  end

  always_ff @(negedge tx_bit_clock_i) begin
    fall_ff <= nxt_fall;
  end

  // Negative rail uses the very same edge as positive
  assign pos_mark_o = cfg_i.sample_rise ? rise_ff.rise_pos : fall_ff.pos;
  assign neg_mark_o = cfg_i.sample_rise ? rise_ff.rise_neg : fall_ff.neg;

endmodule

// file: core/txli_top.sv
/*
  Transmit line interface input stage: AHB-Lite control/status,
  transmitter enable, edge select, rail handling, build-out select.
  Assumes an AHB-Lite master on core_clk_i and a link clock from the
  terminal equipment on tx_bit_clock.
*/
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module txli_top (
  // Core clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   nrst_i,
  // AHB-Lite slave
  input  wire logic                   hsel_i,
  input  wire logic [31:0]            haddr_i,
  input  wire logic [1:0]             htrans_i,
  input  wire logic                   hwrite_i,
  input  wire logic [2:0]             hsize_i,
  input  wire logic [31:0]            hwdata_i,
  input  wire logic                   hready_i,
  output logic [31:0]                 hrdata_o,
  output logic                        hreadyout_o,
  output logic                        hresp_o,
  // Link side
  input  wire logic                   tx_bit_clock_i,
  input  wire logic                   tx_positive_rail_in_i,
  input  wire logic                   tx_negative_rail_in_i,
  // Control pins
  input  wire logic                   transmitter_on_in_i,
  input  wire logic                   tx_edge_select_in_i,
  input  wire logic                   build_out_select_in_i,
  input  wire logic                   hw_single_rail_i,
  input  wire txli_pkg::txli_rate_t   hw_rate_i,
  // Serial port clock in host mode
  output logic                        sport_clk_o,
  // Line driver
  output logic                        line_tip_out_o,
  output logic                        line_tip_out_oe_o,
  output logic                        line_ring_out_o,
  output logic                        line_ring_out_oe_o,
  output logic                        lbo_enable_o
);
  import txli_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Core-domain state

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [1:0]  on_sync;
    logic [1:0]  edge_sync;
    logic [1:0]  lbo_sync;
    logic [1:0]  sr_sync;
    logic [3:0]  rate_sync;
    logic [1:0]  pos_sync;
    logic [1:0]  neg_sync;
    logic        tip;
    logic        ring;
    logic        drive;
    logic        lbo_en;
    logic        sclk;
  } txli_core_st_t;

  txli_core_st_t st_ff;
  txli_core_st_t nxt_st;

  // Link domain registers, separate process
  logic [1:0] lk_rst_ff;
  logic [1:0] lk_host_ff;
  logic [1:0] lk_sr_ff;
  logic [1:0] lk_rise_ff;
  txli_cfg_t  lk_cfg;
  txli_rails_t lk_rails;
  logic       pos_mark;
  logic       neg_mark;

  ////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic word_access(input logic [2:0] size);
    word_access = (size == 3'b010);
  endfunction

  function automatic logic rate_is_ds3_sts(input txli_rate_t rate);
    rate_is_ds3_sts = (rate == TXLI_RATE_DS3) || (rate == TXLI_RATE_STS);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Derived configuration

  logic       host_mode;
  logic       single_rail;
  logic       sample_rise;
  txli_rate_t rate_sel;
  logic       addr_phase;

  assign host_mode   = st_ff.ctrl[CTRL_HOST_BIT];
  assign rate_sel    = host_mode ? txli_rate_t'(st_ff.ctrl[CTRL_RATE_LSB +: CTRL_RATE_W])
                                 : txli_rate_t'(st_ff.rate_sync[3:2]);
  assign single_rail = host_mode ? st_ff.ctrl[CTRL_SINGLE_BIT] : st_ff.sr_sync[1];
  // Edge choice: register in host mode, pin otherwise
  assign sample_rise = host_mode ? st_ff.ctrl[CTRL_EDGE_BIT]
                                 : st_ff.edge_sync[1];
  assign addr_phase  = hsel_i && hready_i && htrans_i[1];

  ////////////////////////////////////////////////////////////////////
  // Core next-state

  always_comb begin
    nxt_st = st_ff;
    nxt_st.on_sync   = {st_ff.on_sync[0],   transmitter_on_in_i};
    nxt_st.edge_sync = {st_ff.edge_sync[0], tx_edge_select_in_i};
    nxt_st.lbo_sync  = {st_ff.lbo_sync[0],  build_out_select_in_i};
    nxt_st.sr_sync   = {st_ff.sr_sync[0],   hw_single_rail_i};
    // Rate pins are asynchronous too; two flops before use
    nxt_st.rate_sync = {st_ff.rate_sync[1:0], hw_rate_i};
    nxt_st.pos_sync  = {st_ff.pos_sync[0],  pos_mark};
    nxt_st.neg_sync  = {st_ff.neg_sync[0],  neg_mark};

    // Bus data phase write
    nxt_st.wr_pend = 1'b0;
    if (st_ff.wr_pend && st_ff.wr_addr == CTRL_OFFS) begin
      nxt_st.ctrl = hwdata_i & CTRL_MASK;
    end
    if (addr_phase) begin
      nxt_st.wr_pend = hwrite_i && word_access(hsize_i);
      nxt_st.wr_addr = haddr_i[7:0];
      nxt_st.rdata   = '0;
      if (!hwrite_i) begin
        unique case (haddr_i[7:0])
          CTRL_OFFS:   nxt_st.rdata = st_ff.ctrl;
          STATUS_OFFS: begin
            nxt_st.rdata[STAT_ON_BIT]   = st_ff.drive;
            nxt_st.rdata[STAT_RISE_BIT] = sample_rise;
            nxt_st.rdata[STAT_LBO_BIT]  = st_ff.lbo_en;
            nxt_st.rdata[STAT_SCLK_BIT] = st_ff.sclk;
            nxt_st.rdata[STAT_POS_BIT]  = st_ff.tip;
            nxt_st.rdata[STAT_NEG_BIT]  = st_ff.ring;
          end
          default:     nxt_st.rdata = '0;
        endcase
      end
    end

    // Pin alone gates the driver, whatever the registers hold
    nxt_st.drive = st_ff.on_sync[1];
    // Marks to line pulses; zero gives no pulse
    nxt_st.tip   = st_ff.pos_sync[1];
    nxt_st.ring  = st_ff.neg_sync[1] & ~single_rail;
    // Build-out: pin only counts in hardware DS3/STS-1; else stays enabled
    if (!host_mode && rate_is_ds3_sts(rate_sel)) begin
      nxt_st.lbo_en = ~st_ff.lbo_sync[1];
    end else begin
      nxt_st.lbo_en = 1'b1;
    end
    // Shared pin becomes serial clock in host mode
    nxt_st.sclk = host_mode & st_ff.edge_sync[1];

    if (!nrst_i) begin
      nxt_st       = '0;
      nxt_st.ctrl  = CTRL_RESET;
      nxt_st.lbo_en = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    st_ff <= nxt_st;
  end

  ////////////////////////////////////////////////////////////////////
  // Link-domain configuration crossing (levels, two flops)

  always_ff @(posedge tx_bit_clock_i) begin
    lk_rst_ff  <= {lk_rst_ff[0], nrst_i};
    lk_host_ff <= {lk_host_ff[0], host_mode};
    lk_sr_ff   <= {lk_sr_ff[0], single_rail};
    lk_rise_ff <= {lk_rise_ff[0], sample_rise};
  end

  assign lk_cfg.host_mode   = lk_host_ff[1];
  assign lk_cfg.single_rail = lk_sr_ff[1];
  assign lk_cfg.sample_rise = lk_rise_ff[1];
  assign lk_rails.pos       = tx_positive_rail_in_i;
  assign lk_rails.neg       = tx_negative_rail_in_i;

  // Pins are sampled directly by the link clock itself
  txli_sampler u_sampler (
    .tx_bit_clock_i (tx_bit_clock_i),
    .link_rst_n_i (lk_rst_ff[1]),
    .cfg_i        (lk_cfg),
    .rails_i      (lk_rails),
    .pos_mark_o   (pos_mark),
    .neg_mark_o   (neg_mark)
  );

  ////////////////////////////////////////////////////////////////////
  // Outputs

  // Tri-state when off, in either mode
  assign line_tip_out_o     = st_ff.drive & st_ff.tip;
  assign line_ring_out_o    = st_ff.drive & st_ff.ring;
  assign line_tip_out_oe_o  = st_ff.drive;
  assign line_ring_out_oe_o = st_ff.drive;
  assign lbo_enable_o       = st_ff.lbo_en;
  assign sport_clk_o        = st_ff.sclk;
  assign hrdata_o           = st_ff.rdata;
  assign hreadyout_o        = 1'b1;
  assign hresp_o            = 1'b0;

endmodule

// file: tb/txli_asserts.sv
/*
  Checker of the transmit line input stage, bound to txli_top.
  Assumes control pins are held for several core cycles at a time.
*/
`timescale 1ns/100ps
module txli_chk (
  // Clock and reset
  input wire logic                 core_clk_i,
  input wire logic                 nrst_i,
  // Control pins
  input wire logic                 transmitter_on_in_i,
  input wire logic                 tx_edge_select_in_i,
  input wire logic                 build_out_select_in_i,
  input wire txli_pkg::txli_rate_t hw_rate_i,
  // Outputs
  input wire logic                 sport_clk_o,
  input wire logic                 line_tip_out_o,
  input wire logic                 line_tip_out_oe_o,
  input wire logic                 line_ring_out_o,
  input wire logic                 line_ring_out_oe_o,
  input wire logic                 lbo_enable_o
);
  import txli_pkg::*;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////
  // Pins cross a two-flop sync, so five steady cycles settle them
  on_drive_a: assert property (transmitter_on_in_i [*5] |-> line_tip_out_oe_o)
    else $error("not driving while on");
  off_hiz_a: assert property (!transmitter_on_in_i [*5] |-> !line_ring_out_oe_o)
    else $error("driving while off");
  oe_pair_a: assert property (line_tip_out_oe_o == line_ring_out_oe_o)
    else $error("enables differ");
  tip_gate_a: assert property (!transmitter_on_in_i [*5] |-> !line_tip_out_o)
    else $error("tip mark while off");
  ring_gate_a: assert property (!transmitter_on_in_i [*5] |-> !line_ring_out_o)
    else $error("ring mark while off");
  lbo_low_a: assert property (!build_out_select_in_i [*5] |-> lbo_enable_o)
    else $error("build-out off, select low");
  lbo_e3_a: assert property ((hw_rate_i == TXLI_RATE_E3) [*5] |-> lbo_enable_o)
    else $error("build-out off at E3");
  sport_low_a: assert property (!tx_edge_select_in_i [*5] |-> !sport_clk_o)
    else $error("serial clock without pin");
  cover property ($rose(line_tip_out_oe_o));
  cover property ($fell(lbo_enable_o));
  cover property ($rose(sport_clk_o));
endmodule
bind txli_top txli_chk u_chk (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .hw_rate_i(hw_rate_i),
  .transmitter_on_in_i(transmitter_on_in_i), .tx_edge_select_in_i(tx_edge_select_in_i),
  .build_out_select_in_i(build_out_select_in_i), .sport_clk_o(sport_clk_o),
  .line_tip_out_o(line_tip_out_o), .line_tip_out_oe_o(line_tip_out_oe_o),
  .line_ring_out_o(line_ring_out_o), .line_ring_out_oe_o(line_ring_out_oe_o),
  .lbo_enable_o(lbo_enable_o));

// file: tb/txli_framer.sv
/*
  Terminal equipment model: free-running bit clock and two rails.
  Assumes the bench names the edge on which the device should sample.
*/
`timescale 1ns/100ps
module txli_framer (
  // Commands from the bench
  input  wire logic rise_i,
  input  wire logic pos_i,
  input  wire logic neg_i,
  input  wire logic single_i,
  input  wire logic junk_i,
  // Link clock and rails
  output logic      tx_bit_clock_o,
  output logic      pos_o,
  output logic      neg_o
);
  logic tie_low;
  assign tie_low = single_i & ~junk_i;
  initial begin
    tx_bit_clock_o = 1'b0;
    #3.3;
    forever #7.5 tx_bit_clock_o = ~tx_bit_clock_o;
  end
  ////////////////////////////////////////////////////////////
  // Data right only near the sampling edge, so a wrong edge reads the inverse
  always @(tx_bit_clock_o) begin
    if (tx_bit_clock_o === rise_i) begin
      #2;
      pos_o = ~pos_i;
      neg_o = ~neg_i & ~tie_low;
      #8;
      pos_o = pos_i;
      neg_o = neg_i & ~tie_low;
    end
  end
endmodule

// file: tb/txli_tb.sv
/*
  Testbench of txli_top: AHB-Lite register access, control pins and
  rail data from the framer model. Assumes the checker is bound.
*/
`timescale 1ns/100ps
module txli_tb;
  import txli_pkg::*;
  logic        core_clk_i, nrst_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, q;
  logic [1:0]  htrans_i = 2'h0;
  logic        on = 1'b0, sel = 1'b0, bld = 1'b0, sgl = 1'b0, rise = 1'b0;
  logic        pos = 1'b1, neg = 1'b0, junk = 1'b0;
  logic        rdy, hresp, spc, tip, toe, ring, roe, lbo, bclk, prl, nrl;
  txli_rate_t  rate = TXLI_RATE_E3;
  int          mismatches = 0, n_checks = 0, cycles = 0;
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  txli_framer u_fr (.rise_i(rise), .pos_i(pos), .neg_i(neg), .single_i(sgl),
    .junk_i(junk), .tx_bit_clock_o(bclk), .pos_o(prl), .neg_o(nrl));
  txli_top dut (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(rdy), .hrdata_o(hrdata_o), .hreadyout_o(rdy), .hresp_o(hresp),
    .tx_bit_clock_i(bclk), .tx_positive_rail_in_i(prl), .tx_negative_rail_in_i(nrl),
    .transmitter_on_in_i(on), .tx_edge_select_in_i(sel), .build_out_select_in_i(bld),
    .hw_single_rail_i(sgl), .hw_rate_i(rate), .sport_clk_o(spc), .line_tip_out_o(tip),
    .line_tip_out_oe_o(toe), .line_ring_out_o(ring), .line_ring_out_oe_o(roe),
    .lbo_enable_o(lbo));
  ////////////////////////////////////////////////////////////
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %0t: reg %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %0t: pin %b not %b", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= HTRANS_NONSEQ;
    do @(posedge core_clk_i); while (rdy !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge core_clk_i); while (rdy !== 1'b1);
    q = hrdata_o;
    chk_pin(hresp, 1'b0);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk_reg(q, exp);
  endtask
  // Long enough for config sync, a bit period and the output sync
  task automatic settle;
    repeat (30) @(posedge core_clk_i);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      final_report;
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    settle;
    // Status tip bit shows the synced mark even while the driver is off
    rd(32'(STATUS_OFFS), 32'h0000_0014);
    bus(1'b1, 32'h0000_0008, 32'h0000_003F);
    rd(32'h0000_0008, 32'h0000_0000);
    rd(32'(CTRL_OFFS), 32'h0000_0000);
    on <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      for (int p = 0; p < 4; p++) begin
        sel <= e[0];
        rise <= e[0];
        pos <= p[1];
        neg <= p[0];
        settle;
        chk_pin(tip, p[1]);
        chk_pin(ring, p[0]);
      end
    end
    chk_pin(toe & roe, 1'b1);
    sgl <= 1'b1;
    junk <= 1'b1;
    pos <= 1'b1;
    neg <= 1'b1;
    settle;
    chk_pin(ring, 1'b0);
    sgl <= 1'b0;
    for (int r = 0; r < 3; r++) begin
      for (int b = 0; b < 2; b++) begin
        rate <= txli_rate_t'(r);
        bld <= b[0];
        settle;
        chk_pin(lbo, ~(b[0] & (r != 0)));
      end
    end
    junk <= 1'b0;
    neg <= 1'b0;
    sel <= 1'b0;
    bus(1'b1, 32'(CTRL_OFFS), 32'h0000_0015);
    rd(32'(CTRL_OFFS), 32'h0000_0015);
    settle;
    chk_pin(tip, 1'b1);
    chk_pin(lbo, 1'b1);
    chk_pin(spc, 1'b0);
    bus(1'b1, 32'(CTRL_OFFS), 32'h0000_0013);
    sel <= 1'b1;
    rise <= 1'b0;
    junk <= 1'b1;
    neg <= 1'b1;
    settle;
    chk_pin(spc, 1'b1);
    chk_pin(tip, 1'b1);
    chk_pin(ring, 1'b0);
    on <= 1'b0;
    settle;
    chk_pin(toe | roe, 1'b0);
    chk_pin(tip | ring, 1'b0);
    rd(32'(STATUS_OFFS), 32'h0000_001C);
    on <= 1'b1;
    settle;
    rd(32'(STATUS_OFFS), 32'h0000_001D);
    final_report;
  end
endmodule
